// ---- rtl/bwr_pkg.sv ----
// Package: constants and types of the block write request issuer
// Operation
// - Address cycle: command, cause, target, address, valid
// - One address cycle then 8 or 16 data
// - Writeback carries former state, way, cmd bit 0
// - Uncached block carries attribute, cmd bit 0 low
// - Data cycle: bit 11, quality, type, data, valid
// - Last data cycle carries last-data type code
// - Gaps between data only with slow cache clock
// - Address cycle only while holding bus mastership
// - Start only if write-ready asserted two cycles before; the issuer samples it four cycles before the address cycle
// - Hold off while conflicting coherency request outstanding
// - Request bus, wait grant and release, then drive
package bwr_pkg;

  localparam int unsigned CMD_W = 12;
  localparam int unsigned AD_W = 64;
  localparam int unsigned PA_W = 40;

  // Command field positions
  localparam int unsigned CMD_DATA_BIT = 11;
  localparam int unsigned CMD_OP_LSB = 5;
  localparam int unsigned CMD_CAUSE_LSB = 3;
  localparam int unsigned CMD_STATE_LSB = 1;
  localparam int unsigned CMD_WB_BIT = 0;
  localparam int unsigned CMD_QUAL_BIT = 5;
  localparam int unsigned CMD_TYPE_LSB = 3;

  // Address-cycle bus field positions
  localparam int unsigned AD_TARGET_LSB = 60;
  localparam int unsigned AD_ATTR_LSB = 58;
  localparam int unsigned AD_WAY_BIT = 57;
  localparam int unsigned AD_STATE_LSB = 1;

  // Encodings
  localparam logic [2:0] CMD_BLOCK_WRITE = 3'h2;
  localparam logic [1:0] TYPE_REQ_DATA = 2'h0;
  localparam logic [1:0] TYPE_REQ_LAST = 2'h1;

  // Index of the last data cycle for short and long lines
  localparam logic [3:0] LAST_SHORT = 4'h7;
  localparam logic [3:0] LAST_LONG = 4'hf;

  // Reset values
  localparam logic [CMD_W-1:0] CMD_RESET = 12'h000;
  localparam logic [AD_W-1:0] AD_RESET = 64'h0000000000000000;

  localparam int unsigned BUF_DEPTH = 2;

  typedef struct packed {
    logic is_writeback;
    logic long_line;
    logic [1:0] cause;
    logic [3:0] target;
    logic [1:0] attr;
    logic [1:0] former_state;
    logic way;
    logic [PA_W-1:0] paddr;
  } bwr_req_s;

  typedef struct packed {
    logic quality;
    logic [AD_W-1:0] data;
  } bwr_word_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAIT,
    ST_ADDR,
    ST_DATA
  } bwr_state_e;

endpackage : bwr_pkg

// ---- rtl/bwr_buffer.sv ----
// Two-entry valid/ready buffer in the write data path
`timescale 1ns/100ps
module bwr_buffer #(
  parameter int unsigned WIDTH = 65,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic full_o
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } bwr_buf_s;

  bwr_buf_s s_reg;
  bwr_buf_s s_next;
  logic push;
  logic pop;

  // Count is one bit wider than the pointers, so full is the whole depth
  assign in_ready_o = (s_reg.count != (PW + 1)'(DEPTH));
  assign out_valid_o = (s_reg.count != '0);
  assign out_data_o = s_reg.mem[s_reg.rd_ptr];
  assign full_o = !in_ready_o;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = in_data_i;
      s_next.wr_ptr = (s_reg.wr_ptr == PW'(DEPTH - 1)) ? '0 :
                      s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = (s_reg.rd_ptr == PW'(DEPTH - 1)) ? '0 :
                      s_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : bwr_buffer

// ---- rtl/bwr_issuer.sv ----
// Block write request issuer on the multiplexed system interface
`timescale 1ns/100ps
module bwr_issuer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Request from the cache side
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire bwr_pkg::bwr_req_s req_i,
  // Write data stream
  input wire logic data_valid_i,
  output logic data_ready_o,
  input wire bwr_pkg::bwr_word_s data_i,
  // Configuration and coherency status
  input wire logic sc_clock_slow_i,
  input wire logic coherency_conflict_i,
  // Arbitration pins
  output logic bus_request_n_o,
  input wire logic bus_grant_n_i,
  input wire logic bus_release_n_i,
  input wire logic write_ready_n_i,
  // Multiplexed bus, output enables low while driving
  output logic [bwr_pkg::CMD_W-1:0] command_bus_o,
  output logic command_bus_oe_n_o,
  output logic [bwr_pkg::AD_W-1:0] addr_data_bus_o,
  output logic addr_data_bus_oe_n_o,
  output logic cycle_valid_n_o,
  output logic cycle_valid_oe_n_o,
  // Status
  output logic master_o,
  output logic done_o
);

  typedef struct packed {
    bwr_pkg::bwr_state_e st;
    bwr_pkg::bwr_req_s req;
    logic [3:0] beat;
    logic master;
    logic gnt_m;
    logic gnt_s;
    logic rel_m;
    logic rel_s;
    logic wrdy_m;
    logic wrdy_s;
    logic req_ready;
    logic bus_req_n;
    logic [bwr_pkg::CMD_W-1:0] cmd;
    logic [bwr_pkg::AD_W-1:0] ad;
    logic val_n;
    logic oe_n;
    logic done;
  } bwr_ctl_s;

  bwr_ctl_s s_reg;
  bwr_ctl_s s_next;

  logic buf_valid;
  logic buf_full;
  logic buf_pop;
  bwr_pkg::bwr_word_s buf_word;
  logic may_start;
  logic data_ok;
  logic [3:0] last_beat;

  bwr_buffer #(
    .WIDTH($bits(bwr_pkg::bwr_word_s)),
    .DEPTH(bwr_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(data_valid_i),
    .in_ready_o(data_ready_o),
    .in_data_i(data_i),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_word),
    .full_o(buf_full)
  );

  assign last_beat = s_reg.req.long_line ? bwr_pkg::LAST_LONG :
                     bwr_pkg::LAST_SHORT;
  // Fast cache clock forbids gaps, so only start with the buffer full
  assign data_ok = sc_clock_slow_i ? buf_valid : buf_full;
  // Second sync stage shows the pin two cycles before this decision, so four cycles before the address cycle
  assign may_start = s_reg.master && !s_reg.wrdy_s &&
                     !coherency_conflict_i && data_ok;
  assign buf_pop = (s_reg.st == bwr_pkg::ST_DATA) && buf_valid;

  always_comb begin
    s_next = s_reg;
    s_next.gnt_m = bus_grant_n_i;
    s_next.gnt_s = s_reg.gnt_m;
    s_next.rel_m = bus_release_n_i;
    s_next.rel_s = s_reg.rel_m;
    s_next.wrdy_m = write_ready_n_i;
    s_next.wrdy_s = s_reg.wrdy_m;
    s_next.val_n = 1'b1;
    s_next.done = 1'b0;
    // Mastership returns to the agent once it negates the grant while idle
    if (s_reg.master && s_reg.gnt_s && s_reg.st == bwr_pkg::ST_IDLE) begin
      s_next.master = 1'b0;
    end
    case (s_reg.st)
      bwr_pkg::ST_IDLE: begin
        if (req_valid_i && s_reg.req_ready) begin
          s_next.req = req_i;
          s_next.req_ready = 1'b0;
          if (s_next.master) begin
            s_next.st = bwr_pkg::ST_WAIT;
          end else begin
            s_next.bus_req_n = 1'b0;
            s_next.st = bwr_pkg::ST_REQ;
          end
        end
      end
      bwr_pkg::ST_REQ: begin
        if (!s_reg.gnt_s && !s_reg.rel_s) begin
          s_next.master = 1'b1;
          s_next.st = bwr_pkg::ST_WAIT;
        end
      end
      bwr_pkg::ST_WAIT: begin
        s_next.oe_n = 1'b0;
        // The agent took the bus back after the last request: ask again
        if (s_reg.gnt_s) begin
          s_next.master = 1'b0;
          s_next.bus_req_n = 1'b0;
          s_next.st = bwr_pkg::ST_REQ;
        end else if (may_start) begin
          s_next.st = bwr_pkg::ST_ADDR;
        end
      end
      bwr_pkg::ST_ADDR: begin
        s_next.cmd = bwr_pkg::CMD_RESET;
        s_next.cmd[bwr_pkg::CMD_DATA_BIT] = 1'b0;
        s_next.cmd[bwr_pkg::CMD_OP_LSB +: 3] = bwr_pkg::CMD_BLOCK_WRITE;
        s_next.cmd[bwr_pkg::CMD_CAUSE_LSB +: 2] = s_reg.req.cause;
        s_next.ad = bwr_pkg::AD_RESET;
        s_next.ad[bwr_pkg::AD_TARGET_LSB +: 4] = s_reg.req.target;
        s_next.ad[bwr_pkg::PA_W-1:0] = s_reg.req.paddr;
        if (s_reg.req.is_writeback) begin
          s_next.cmd[bwr_pkg::CMD_STATE_LSB +: 2] =
            s_reg.req.former_state;
          s_next.cmd[bwr_pkg::CMD_WB_BIT] = 1'b1;
          s_next.ad[bwr_pkg::AD_STATE_LSB +: 2] = s_reg.req.former_state;
          s_next.ad[bwr_pkg::AD_WAY_BIT] = s_reg.req.way;
        end else begin
          s_next.ad[bwr_pkg::AD_ATTR_LSB +: 2] = s_reg.req.attr;
          s_next.cmd[bwr_pkg::CMD_WB_BIT] = 1'b0;
        end
        s_next.val_n = 1'b0;
        s_next.beat = 4'h0;
        s_next.st = bwr_pkg::ST_DATA;
      end
      bwr_pkg::ST_DATA: begin
        if (buf_valid) begin
          s_next.cmd = bwr_pkg::CMD_RESET;
          s_next.cmd[bwr_pkg::CMD_DATA_BIT] = 1'b1;
          s_next.cmd[bwr_pkg::CMD_QUAL_BIT] = buf_word.quality;
          s_next.cmd[bwr_pkg::CMD_TYPE_LSB +: 2] =
            (s_reg.beat == last_beat) ? bwr_pkg::TYPE_REQ_LAST :
            bwr_pkg::TYPE_REQ_DATA;
          s_next.ad = buf_word.data;
          s_next.val_n = 1'b0;
          s_next.beat = s_reg.beat + 4'h1;
          if (s_reg.beat == last_beat) begin
            s_next.bus_req_n = 1'b1;
            s_next.done = 1'b1;
            s_next.req_ready = 1'b1;
            s_next.st = bwr_pkg::ST_IDLE;
          end
        end
        // An empty buffer leaves a gap, legal only with a slow cache clock
      end
      default: begin
        s_next.st = bwr_pkg::ST_IDLE;
      end
    endcase
    if (!s_next.master) begin
      s_next.oe_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= bwr_pkg::ST_IDLE;
      s_reg.gnt_m <= 1'b1;
      s_reg.gnt_s <= 1'b1;
      s_reg.rel_m <= 1'b1;
      s_reg.rel_s <= 1'b1;
      s_reg.wrdy_m <= 1'b1;
      s_reg.wrdy_s <= 1'b1;
      s_reg.req_ready <= 1'b1;
      s_reg.bus_req_n <= 1'b1;
      s_reg.val_n <= 1'b1;
      s_reg.oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign req_ready_o = s_reg.req_ready;
  assign bus_request_n_o = s_reg.bus_req_n;
  assign command_bus_o = s_reg.cmd;
  assign command_bus_oe_n_o = s_reg.oe_n;
  assign addr_data_bus_o = s_reg.ad;
  assign addr_data_bus_oe_n_o = s_reg.oe_n;
  assign cycle_valid_n_o = s_reg.val_n;
  assign cycle_valid_oe_n_o = s_reg.oe_n;
  assign master_o = s_reg.master;
  assign done_o = s_reg.done;

endmodule : bwr_issuer

// ---- verification/bwr_issuer_chk.sv ----
// Bus checker of the block write request issuer
`timescale 1ns/100ps
module bwr_issuer_chk (
  // Clock, reset and watched ports
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sc_clock_slow_i,
  input wire logic coherency_conflict_i,
  input wire logic bus_grant_n_i,
  input wire logic write_ready_n_i,
  input wire logic [bwr_pkg::CMD_W-1:0] command_bus_o,
  input wire logic [bwr_pkg::AD_W-1:0] addr_data_bus_o,
  input wire logic cycle_valid_n_o,
  input wire logic master_o,
  input wire logic done_o,
  input wire logic bus_request_n_o,
  input wire logic command_bus_oe_n_o,
  input wire logic addr_data_bus_oe_n_o,
  input wire logic cycle_valid_oe_n_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  logic adr;
  logic dat;
  logic [4:0] beat_reg;
  assign adr = !cycle_valid_n_o && !command_bus_o[11];
  assign dat = !cycle_valid_n_o && command_bus_o[11];
  // Data cycles seen since the last address cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) beat_reg <= 5'h00;
    else if (adr) beat_reg <= 5'h00;
    else if (dat) beat_reg <= beat_reg + 5'h01;
  end
  addr_cmd_a: assert property (
    adr |-> command_bus_o[7:5] == bwr_pkg::CMD_BLOCK_WRITE)
    else $error("bad address command");
  wb_state_a: assert property (
    adr && command_bus_o[0] |-> addr_data_bus_o[2:1] == command_bus_o[2:1])
    else $error("former state differs");
  addr_master_a: assert property (adr |-> master_o)
    else $error("address cycle while not master");
  wr_ready_a: assert property (adr |-> !$past(write_ready_n_i, 2))
    else $error("address cycle without write ready");
  no_conflict_a: assert property (
    adr |-> !$past(coherency_conflict_i, 2))
    else $error("address cycle during conflict");
  fast_data_a: assert property (
    (adr || dat && command_bus_o[4:3] == bwr_pkg::TYPE_REQ_DATA)
    && !sc_clock_slow_i |=> dat)
    else $error("gap in fast data");
  last_beat_a: assert property (
    dat && command_bus_o[4:3] == bwr_pkg::TYPE_REQ_LAST
    |-> done_o && (beat_reg == 5'h07 || beat_reg == 5'h0f))
    else $error("last data at wrong beat");
  grant_seen_a: assert property (
    $rose(master_o) |-> !$past(bus_grant_n_i, 2))
    else $error("master without grant");
  drive_en_a: assert property (
    !cycle_valid_n_o |-> !command_bus_oe_n_o && !addr_data_bus_oe_n_o
    && !cycle_valid_oe_n_o)
    else $error("valid cycle without drive enable");
  oe_master_a: assert property (
    !command_bus_oe_n_o |-> master_o)
    else $error("bus driven while not master");
  req_held_a: assert property (
    $rose(master_o) |-> $past(!bus_request_n_o) && !bus_request_n_o)
    else $error("master without bus request");
endmodule : bwr_issuer_chk

bind bwr_issuer bwr_issuer_chk u_bwr_issuer_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .master_o(master_o),
  .sc_clock_slow_i(sc_clock_slow_i), .done_o(done_o),
  .coherency_conflict_i(coherency_conflict_i),
  .bus_grant_n_i(bus_grant_n_i), .write_ready_n_i(write_ready_n_i),
  .command_bus_o(command_bus_o), .addr_data_bus_o(addr_data_bus_o),
  .cycle_valid_n_o(cycle_valid_n_o),
  .bus_request_n_o(bus_request_n_o),
  .command_bus_oe_n_o(command_bus_oe_n_o),
  .addr_data_bus_oe_n_o(addr_data_bus_oe_n_o),
  .cycle_valid_oe_n_o(cycle_valid_oe_n_o)
);

// ---- verification/bwr_agent.sv ----
// Model of the external agent that grants the system interface
`timescale 1ns/100ps
module bwr_agent (
  // Clock, reset and bench control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] lag_i,
  input wire logic wr_hold_i,
  // Device pins
  input wire logic bus_request_n_i,
  output logic bus_grant_n_o,
  output logic bus_release_n_o,
  output logic write_ready_n_o
);
  logic [3:0] wait_reg;
  // Grant is withdrawn once the request drops, taking mastership back
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg <= 4'h0;
      bus_grant_n_o <= 1'b1;
      write_ready_n_o <= 1'b1;
    end else begin
      wait_reg <= bus_request_n_i ? 4'h0 : wait_reg + {3'h0, !wait_reg[3]};
      bus_grant_n_o <= bus_request_n_i || wait_reg < {1'b0, lag_i};
      write_ready_n_o <= wr_hold_i;
    end
  end
  assign bus_release_n_o = bus_grant_n_o;
endmodule : bwr_agent

// ---- verification/tb_bwr_issuer.sv ----
// Self-checking bench of the block write request issuer
`timescale 1ns/100ps
module tb_bwr_issuer;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic data_valid_i = 1'b0;
  logic sc_clock_slow_i = 1'b0;
  logic coherency_conflict_i = 1'b0;
  logic wr_hold = 1'b0;
  logic [2:0] lag = 3'h0;
  bwr_pkg::bwr_req_s req_i = '0;
  bwr_pkg::bwr_word_s data_i = '0;
  logic req_ready_o, data_ready_o, bus_request_n_o, cycle_valid_n_o;
  logic master_o, done_o, gnt_n, rel_n, wrr_n;
  logic [11:0] command_bus_o;
  logic [63:0] addr_data_bus_o;
  logic [75:0] exp_q[$];
  logic [31:0] seed = 32'h16;
  int failures = 0, checks = 0, cyc = 0, acyc = 0, t_rel = 0;

  bwr_issuer u_bwr_issuer (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .data_i(data_i),
    .data_valid_i(data_valid_i), .data_ready_o(data_ready_o),
    .sc_clock_slow_i(sc_clock_slow_i),
    .coherency_conflict_i(coherency_conflict_i),
    .bus_request_n_o(bus_request_n_o), .bus_grant_n_i(gnt_n),
    .bus_release_n_i(rel_n), .write_ready_n_i(wrr_n),
    .command_bus_o(command_bus_o), .command_bus_oe_n_o(),
    .addr_data_bus_o(addr_data_bus_o), .addr_data_bus_oe_n_o(),
    .cycle_valid_n_o(cycle_valid_n_o), .cycle_valid_oe_n_o(),
    .master_o(master_o), .done_o(done_o));
  bwr_agent u_bwr_agent (
    .clk_i(sys_clk_i), .rst_i(rst_i), .lag_i(lag), .wr_hold_i(wr_hold),
    .bus_request_n_i(bus_request_n_o), .bus_grant_n_o(gnt_n),
    .bus_release_n_o(rel_n), .write_ready_n_o(wrr_n));

  always #20 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_sim();
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic chk(string name, logic [75:0] e, logic [75:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", name, e, g);
    end
  endtask : chk

  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask : tick

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      end_sim();
    end
  end

  // Only cycles with valid asserted are taken from the bus
  always @(negedge sys_clk_i) begin
    if (cycle_valid_n_o === 1'b0) begin
      if (!command_bus_o[11]) acyc = cyc;
      chk("bus", exp_q.pop_front(), {command_bus_o, addr_data_bus_o});
    end
  end

  task automatic run(logic [2:0] m);
    bwr_pkg::bwr_req_s r;
    logic [10:0] x;
    int k;
    {x, r} = {rnd(), rnd()};
    r.is_writeback = m[0];
    r.long_line = m[1];
    r.paddr[6:0] = 7'h00;
    exp_q.push_back({4'h0, bwr_pkg::CMD_BLOCK_WRITE, r.cause,
      m[0] ? r.former_state : 2'h0, m[0], r.target,
      m[0] ? 2'h0 : r.attr, m[0] & r.way, 17'h0, r.paddr[39:3],
      m[0] ? r.former_state : 2'h0, 1'b0});
    sc_clock_slow_i = m[2];
    coherency_conflict_i = (m == 3'h3);
    wr_hold = (m == 3'h5);
    lag = x[2:0];
    fork begin
      repeat (30) tick();
      t_rel = cyc;
      coherency_conflict_i = 1'b0;
      wr_hold = 1'b0;
    end join_none
    req_i = r;
    req_valid_i = 1'b1;
    k = 0;
    while (k == 0) begin
      k = req_ready_o;
      tick();
    end
    req_valid_i = 1'b0;
    for (int j = 0; j < (m[1] ? 16 : 8); j++) begin
      if (m[2] && x[j % 8]) begin
        data_valid_i = 1'b0;
        tick();
      end
      data_i.data = {rnd(), rnd()};
      data_i.quality = data_i.data[7];
      exp_q.push_back({1'b1, 5'h0, data_i.quality,
        (j == (m[1] ? 15 : 7)) ? bwr_pkg::TYPE_REQ_LAST
        : bwr_pkg::TYPE_REQ_DATA, 3'h0, data_i.data});
      data_valid_i = 1'b1;
      k = 0;
      while (k == 0) begin
        k = data_ready_o;
        tick();
      end
    end
    data_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 300) begin
      tick();
      k++;
    end
    chk("done", 76'h1, {75'h0, done_o});
    wait fork;
    if (m == 3'h3 || m == 3'h5) chk("held", 76'h1, {75'h0, acyc > t_rel});
  endtask : run

  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      run(i[2:0]);
    end
    repeat (5) tick();
    chk("left", 76'h0, 76'(exp_q.size()));
    end_sim();
  end
endmodule : tb_bwr_issuer
